// ### peripheral_reset_controller.sv
// peripheral reset controller: hold, watchdog select and completion registers
// assumes peripherals and watchdog on sys_clk domain unless flagged; done inputs synchronised
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/100ps
module peripheral_reset_controller
    import reset_ctrl_pkg::*;
#(
    parameter int unsigned n_periph = periph_count
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // power-on state machine and watchdog
    input wire logic por_reset,
    input wire logic watchdog_fire,
    // axi4-lite write address and data
    input wire logic [31:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // axi4-lite write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // axi4-lite read address and data
    input wire logic [31:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // peripheral resets and completions
    output logic [n_periph-1:0] periph_reset,
    input wire logic [n_periph-1:0] periph_done
);
    typedef struct packed {
        logic [n_periph-1:0] hold;
        logic [n_periph-1:0] wd_select;
        logic [n_periph-1:0] done_meta;
        logic [n_periph-1:0] done_sync;
        logic [n_periph-1:0] done;
        logic [n_periph-1:0] wd_pulse;
        logic [n_periph-1:0] reset_out;
    } core_s;

    core_s cur_ff;
    core_s nxt_cur;
    reg_wr_if regs ();

    logic ctl_rst_n;
    assign ctl_rst_n = rst_n && !por_reset;

    axil_reg_slave u_slave (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .regs(regs)
    );

    // merge a strobed write into the low peripheral bits
    function automatic logic [n_periph-1:0] merge(
        input logic [n_periph-1:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] mask;
        logic [31:0] wide;
        mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        wide = 32'h00000000;
        wide[n_periph-1:0] = old;
        wide = (wide & ~mask) | (data & mask);
        return wide[n_periph-1:0];
    endfunction : merge

    function automatic logic [31:0] widen(input logic [n_periph-1:0] v);
        logic [31:0] w;
        w = 32'h00000000;
        w[n_periph-1:0] = v;
        return w;
    endfunction : widen

    // one-hot select of the three registers from a byte offset
    function automatic logic [2:0] reg_sel(input logic [11:0] offs);
        logic [2:0] sel;
        sel = 3'b000;
        unique case (offs)
            hold_offset: sel = 3'b001;
            wd_select_offset: sel = 3'b010;
            done_offset: sel = 3'b100;
            default: sel = 3'b000;
        endcase
        return sel;
    endfunction : reg_sel

    logic [2:0] rd_sel;
    logic [2:0] wr_sel;
    logic [n_periph-1:0] pulse_next;
    logic [n_periph-1:0] reset_next;
    logic [n_periph-1:0] done_next;

    assign rd_sel = reg_sel(regs.rd_addr);
    assign wr_sel = reg_sel(regs.wr_addr);

    always_comb begin
        regs.rd_hit = |rd_sel;
        regs.rd_data = 32'h00000000;
        if (rd_sel[0]) begin
            regs.rd_data = widen(cur_ff.hold);
        end
        if (rd_sel[1]) begin
            regs.rd_data = widen(cur_ff.wd_select);
        end
        if (rd_sel[2]) begin
            regs.rd_data = widen(cur_ff.done);
        end
    end

    assign regs.wr_hit = |wr_sel;

    // per-peripheral reset and completion paths
    for (genvar p = 0; p < n_periph; p++) begin : g_periph
        assign pulse_next[p] = watchdog_fire && cur_ff.wd_select[p];
        assign reset_next[p] = cur_ff.hold[p] || cur_ff.wd_pulse[p];
        // done only while released, so a fresh reset clears it
        assign done_next[p] = cur_ff.done_sync[p] && !cur_ff.reset_out[p];
    end : g_periph

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.done_meta = periph_done;
        nxt_cur.done_sync = cur_ff.done_meta;
        if (regs.wr_en && wr_sel[0]) begin
            nxt_cur.hold = merge(cur_ff.hold, regs.wr_data, regs.wr_strb);
        end
        if (regs.wr_en && wr_sel[1]) begin
            nxt_cur.wd_select = merge(cur_ff.wd_select, regs.wr_data, regs.wr_strb);
        end
        nxt_cur.wd_pulse = pulse_next;
        nxt_cur.reset_out = reset_next;
        nxt_cur.done = done_next;
        if (!ctl_rst_n) begin
            nxt_cur.hold = hold_reset_value[n_periph-1:0];
            nxt_cur.wd_select = wd_select_reset_value[n_periph-1:0];
            nxt_cur.done = done_reset_value[n_periph-1:0];
            nxt_cur.done_meta = '0;
            nxt_cur.done_sync = '0;
            nxt_cur.wd_pulse = '0;
            nxt_cur.reset_out = hold_reset_value[n_periph-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        cur_ff <= nxt_cur;
    end

    assign periph_reset = cur_ff.reset_out;
endmodule : peripheral_reset_controller

// ### reset_ctrl_pkg.sv
// constants for the peripheral reset controller
// assumes a 32-bit axi4-lite register bus on sys_clk
package reset_ctrl_pkg;
    localparam int unsigned periph_count = 25;
    localparam logic [31:0] base_addr = 32'h4000c000;
    localparam logic [11:0] hold_offset = 12'h000;
    localparam logic [11:0] wd_select_offset = 12'h004;
    localparam logic [11:0] done_offset = 12'h008;
    localparam logic [24:0] hold_reset_value = 25'h1ffffff;
    localparam logic [24:0] wd_select_reset_value = 25'h0000000;
    localparam logic [24:0] done_reset_value = 25'h0000000;
    localparam int unsigned usbctrl_bit = 24;
    localparam int unsigned adc_bit = 0;
    localparam int unsigned programmable_io_one_bit = 11;
    localparam int unsigned programmable_io_zero_bit = 10;
    localparam int unsigned user_pad_control_bit = 8;
    localparam int unsigned user_pin_routing_bit = 5;
    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;
endpackage : reset_ctrl_pkg

// ### reg_wr_if.sv
// write and read path between the bus slave and the register core
// assumes both ends on sys_clk
`timescale 1ns/100ps
interface reg_wr_if;
    logic wr_en;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [11:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_hit;
    logic wr_hit;
    modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input rd_data, rd_hit, wr_hit);
    modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output rd_data, rd_hit, wr_hit);
endinterface : reg_wr_if

// ### axil_reg_slave.sv
// axi4-lite slave front end for the reset controller
// assumes one outstanding write and one outstanding read
`timescale 1ns/100ps
module axil_reg_slave
    import reset_ctrl_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // write address and data
    input wire logic [31:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // read address
    input wire logic [31:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    // read data
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // register core side
    reg_wr_if.slave regs
);
    typedef struct packed {
        logic aw_have;
        logic [11:0] aw_addr;
        logic aw_bad;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic awready;
        logic wready;
        logic arready;
    } slave_s;

    slave_s cur_ff;
    slave_s nxt_cur;

    function automatic logic out_of_block(input logic [31:0] a);
        return (a[31:12] != base_addr[31:12]) || (a[1:0] != 2'b00);
    endfunction : out_of_block

    logic do_write;
    assign do_write = cur_ff.aw_have && cur_ff.w_have && !cur_ff.bvalid;
    assign regs.wr_en = do_write && !cur_ff.aw_bad;
    assign regs.wr_addr = cur_ff.aw_addr;
    assign regs.wr_data = cur_ff.w_data;
    assign regs.wr_strb = cur_ff.w_strb;
    assign regs.rd_addr = s_araddr[11:0];

    assign s_awready = cur_ff.awready;
    assign s_wready = cur_ff.wready;
    assign s_arready = cur_ff.arready;
    assign s_bvalid = cur_ff.bvalid;
    assign s_bresp = cur_ff.bresp;
    assign s_rvalid = cur_ff.rvalid;
    assign s_rdata = cur_ff.rdata;
    assign s_rresp = cur_ff.rresp;

    always_comb begin
        nxt_cur = cur_ff;
        if (s_awvalid && !cur_ff.aw_have) begin
            nxt_cur.aw_have = 1'b1;
            nxt_cur.aw_addr = s_awaddr[11:0];
            nxt_cur.aw_bad = out_of_block(s_awaddr);
        end
        if (s_wvalid && !cur_ff.w_have) begin
            nxt_cur.w_have = 1'b1;
            nxt_cur.w_data = s_wdata;
            nxt_cur.w_strb = s_wstrb;
        end
        if (do_write) begin
            nxt_cur.aw_have = 1'b0;
            nxt_cur.w_have = 1'b0;
            nxt_cur.bvalid = 1'b1;
            nxt_cur.bresp = (!cur_ff.aw_bad && regs.wr_hit) ? resp_okay : resp_slverr;
        end
        if (cur_ff.bvalid && s_bready) begin
            nxt_cur.bvalid = 1'b0;
        end
        if (cur_ff.rvalid && s_rready) begin
            nxt_cur.rvalid = 1'b0;
        end
        if (s_arvalid && !cur_ff.rvalid) begin
            nxt_cur.rvalid = 1'b1;
            if (!out_of_block(s_araddr) && regs.rd_hit) begin
                nxt_cur.rdata = regs.rd_data;
                nxt_cur.rresp = resp_okay;
            end else begin
                nxt_cur.rdata = 32'h00000000;
                nxt_cur.rresp = resp_slverr;
            end
        end
        if (!rst_n) begin
            nxt_cur = '0;
        end
        // ready kept as flops so the bus pins come straight from registers
        nxt_cur.awready = !nxt_cur.aw_have;
        nxt_cur.wready = !nxt_cur.w_have;
        nxt_cur.arready = !nxt_cur.rvalid;
    end

    always_ff @(posedge sys_clk) begin
        cur_ff <= nxt_cur;
    end
endmodule : axil_reg_slave

// ### reset_ctrl_assertions.sv
// port checks for the peripheral reset controller
// assumes binding onto the top module, one clock
`timescale 1ns/100ps
module reset_ctrl_assertions
    import reset_ctrl_pkg::*;
#(
    parameter int unsigned n_periph = periph_count
) (
    // clock and resets
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic por_reset,
    // write side
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic [1:0] s_bresp,
    input wire logic s_bvalid,
    input wire logic s_bready,
    // read side
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic [1:0] s_rresp,
    input wire logic s_rvalid,
    input wire logic s_rready,
    // resets out
    input wire logic [n_periph-1:0] periph_reset
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    sequence wr_taken;
        s_awvalid && s_awready && s_wvalid && s_wready && !s_bvalid;
    endsequence
    sequence rd_taken;
        s_arvalid && s_arready;
    endsequence
    a_write_answer: assert property (wr_taken |-> ##2 s_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (rd_taken |=> s_rvalid)
        else $error("read answer late");
    a_bresp_held: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write answer dropped");
    a_rdata_held: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read answer dropped");
    a_read_single: assert property (s_rvalid |-> !s_arready)
        else $error("second read taken");
    a_upper_zero: assert property (s_rvalid |-> s_rdata[31:25] == 7'h00)
        else $error("upper bits set");
    a_refused_zero: assert property (s_rvalid && s_rresp == resp_slverr |-> s_rdata == 32'h0)
        else $error("refused read data");
    a_por_restore: assert property (por_reset |-> ##2 (&periph_reset))
        else $error("power-on reset incomplete");
endmodule : reset_ctrl_assertions
bind peripheral_reset_controller reset_ctrl_assertions #(.n_periph(n_periph)) chk_i (.*);

// ### testbench.sv
// self-checking bench for the peripheral reset controller
// assumes the checker is bound from its own file
`timescale 1ns/100ps
module testbench
    import reset_ctrl_pkg::*;
;
    logic sys_clk = 0, rst_n = 0, por_reset = 0, watchdog_fire = 0;
    logic [31:0] s_awaddr = 0, s_wdata = 0, s_araddr = 0, s_rdata;
    logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [3:0] s_wstrb = 4'hf;
    logic [1:0] s_bresp, s_rresp;
    logic [24:0] periph_reset, periph_done = 0;
    int n_errors = 0, n_checks = 0;
    localparam logic [31:0] a_hld = {base_addr[31:12], hold_offset};
    localparam logic [31:0] a_wds = {base_addr[31:12], wd_select_offset};
    localparam logic [31:0] a_dne = {base_addr[31:12], done_offset};
    peripheral_reset_controller #(.n_periph(25)) uut (.*);
    always #50 sys_clk = ~sys_clk;
    task end_sim;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task tmo(input int i);
        if (i == 20) begin
            n_errors++;
            end_sim;
        end
    endtask : tmo
    // response ready held back one cycle to stall the slave
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            if (s_bvalid && s_bready) break;
            if (s_bvalid) s_bready <= 1'b1;
        end
        s_bready <= 1'b0;
        tmo(i);
        chk({30'h0, s_bresp}, {30'h0, er});
        @(posedge sys_clk);
    endtask : wr
    logic [31:0] rd_val;
    logic [1:0] rd_resp;
    task rd_raw(input logic [31:0] a);
        int i;
        s_araddr <= a;
        s_arvalid <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (s_arready) s_arvalid <= 1'b0;
            if (s_rvalid && s_rready) break;
            if (s_rvalid) s_rready <= 1'b1;
        end
        s_rready <= 1'b0;
        tmo(i);
        rd_val = s_rdata;
        rd_resp = s_rresp;
        @(posedge sys_clk);
    endtask : rd_raw
    task rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
        rd_raw(a);
        chk(rd_val, exp);
        chk({30'h0, rd_resp}, {30'h0, er});
    endtask : rd
    // software waits on the completion bits before touching a released block
    task poll_done(input logic [31:0] bits);
        int k;
        for (k = 0; k < 20; k++) begin
            rd_raw(a_dne);
            if ((rd_val & bits) == bits) break;
        end
        tmo(k);
    endtask : poll_done
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        chk(32'(periph_reset), 32'h01ffffff);
        rd(a_hld, 32'h01ffffff, resp_okay);
        rd(a_wds, 32'h0, resp_okay);
        rd(a_dne, 32'h0, resp_okay);
        wr(a_hld, 32'hfe000f0f, resp_okay);
        rd(a_hld, 32'h00000f0f, resp_okay);
        chk(32'(periph_reset), 32'h00000f0f);
        periph_done <= 25'h1fffff0;
        poll_done(32'h01fff0f0);
        rd(a_dne, 32'h01fff0f0, resp_okay);
        wr(a_dne, 32'h0, resp_okay);
        rd(a_dne, 32'h01fff0f0, resp_okay);
        wr(a_wds, 32'hfe000030, resp_okay);
        rd(a_wds, 32'h00000030, resp_okay);
        watchdog_fire <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(32'(periph_reset), 32'h00000f3f);
        watchdog_fire <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk(32'(periph_reset), 32'h00000f0f);
        rd(base_addr | 32'hc, 32'h0, resp_slverr);
        wr(base_addr | 32'h10, 32'h0, resp_slverr);
        rd(32'h4000d000, 32'h0, resp_slverr);
        rd(a_hld, 32'h00000f0f, resp_okay);
        por_reset <= 1'b1;
        @(posedge sys_clk);
        por_reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk(32'(periph_reset), 32'h01ffffff);
        rd(a_hld, 32'h01ffffff, resp_okay);
        rd(a_wds, 32'h0, resp_okay);
        rd(a_dne, 32'h0, resp_okay);
        end_sim;
    end
endmodule : testbench
